// [verilog/ext_bus_ctrl.sv]
// What this block does
// - Internal-only mode keeps bus idle, pins as ports, control writes blocked.
// - Internal-only mode ignores release bit reset value; pins stay ordinary ports.
// - Extended mode takes bus function on external fetch or table access.
// - Internal-only execution: release bit 0 keeps bus, 1 gives ports.
// - External access with release bit 1 returns pins to bus function.
// - Release set from external code takes effect at branch into internal.
// - Idle bus: address/data tri-state, strobes high, latch strobe and lsb low.
// - Idle tri-state covers all twenty address/data lines, whatever the configured address width.
// - Bus beats every other peripheral for pin ownership in bus modes.
// - Two low control bits select write mode at sixteen-bit width.
// - Sixteen-bit: latch strobe with address, then output enable both bytes.
// - Chip select low on every external access, high in sleep.
// - Byte write: latch byte on both halves, high or low strobe by lsb.
// - Word write even: hold byte, tri-state data phase, no strobe.
// - Word write odd: latch byte upper, held byte lower.
// - Word write: high strobe on odd write only, byte lsb follows pointer, both selects.
// - Byte select: both halves, high strobe only, selects from pointer lsb.
// - Eight-bit width is multiplexed, data on low eight lines.
// - Eight-bit fetch reads two bytes, output enable per half, lsb toggles.
// - Eight-bit table write: latch byte on low eight lines only, byte lsb from pointer lsb.
// - Write mode 1x word, 01 byte select, 00 byte write.
// - Wait field adds 0..3 cycles to table reads and writes for codes 11,10,01,00.
// - Sleep and idle freeze pins, chip select and byte selects high.
//
// Controller for the multiplexed external program memory bus.
// Assumes the core holds a request until done and the pad ring resolves enables.
`timescale 1ns/10ps

module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = 20
)
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  input  wire logic [1:0]        mem_bus_select_in,
  input  wire logic              data_width16_in,
  input  wire logic              wait_enable_in,
  input  wire logic              sleep_in,
  input  wire logic              idle_in,
  input  wire logic              exec_external_in,
  input  wire logic              ctrl_write_in,
  input  wire logic [7:0]        ctrl_wdata_in,
  input  wire logic              req_valid_in,
  input  wire access_req_s       req_in,
  input  wire logic [19:0]       addr_data_in,
  input  wire logic [19:0]       periph_out_in,
  input  wire logic [19:0]       periph_oe_in,
  output logic      [7:0]        bus_control_register_out,
  output logic                   req_done_out,
  output logic      [15:0]       read_word_out,
  output bus_pins_s              pins_out,
  output logic      [19:0]       pin_is_bus_out
);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [7:0] bus_ctrl_reg;
  logic       ext_bus_release;
  logic       release_eff_reg;
  logic       internal_only;
  logic [1:0] write_mode_sel;
  logic [1:0] wait_code;
  logic [1:0] extra_waits;
  write_mode_e wmode;

  assign internal_only   = (mem_bus_select_in == `EMB_INTERNAL);
  assign ext_bus_release = bus_ctrl_reg[`CTRL_RELEASE_BIT];
  assign write_mode_sel  = bus_ctrl_reg[`CTRL_WM_HI:`CTRL_WM_LO];
  assign wait_code       = bus_ctrl_reg[`CTRL_WAIT_HI:`CTRL_WAIT_LO];
  assign bus_control_register_out = bus_ctrl_reg;

  always_comb
  begin
    if (write_mode_sel[1])
      wmode = WMODE_WORD_WRITE;
    else if (write_mode_sel[0])
      wmode = WMODE_BYTE_SELECT;
    else
      wmode = WMODE_BYTE_WRITE;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_ctrl_reg <= `CTRL_RESET;
    else if (clk_en_in && ctrl_write_in && !internal_only)
      bus_ctrl_reg <= ctrl_wdata_in & `CTRL_WRITE_MASK;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      release_eff_reg <= 1'b0;
    else if (clk_en_in && !exec_external_in)
      release_eff_reg <= ext_bus_release;
  end

  assign extra_waits = (wait_enable_in && req_in.kind != ACC_FETCH)
                       ? (`WAIT_MAX - wait_code) : 2'h0;

  // ---------------------------------------------------------------
  // Ownership and sequencing
  // ---------------------------------------------------------------
  logic       powered_down;
  logic       access_go;
  logic       own_bus;
  logic [2:0] phase;
  logic       busy;
  logic       done;

  assign powered_down = sleep_in || idle_in;
  assign access_go = req_valid_in && req_in.external && !internal_only && !powered_down;
  // pin ownership
  // Only setting the release bit waits for internal code; clearing acts at once
  assign own_bus = !internal_only && (busy || !(ext_bus_release && release_eff_reg));
  assign req_done_out = done;

  ext_bus_phase u_phase (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in && !powered_down),
    .start_in   (access_go),
    .extra_in   (extra_waits),
    .phase_out  (phase),
    .busy_out   (busy),
    .done_out   (done)
  );

  logic [19:0] width_mask;
  always_comb
  begin
    case (mem_bus_select_in)
      `EMB_ADDR12: width_mask = 20'h0_0fff;
      `EMB_ADDR16: width_mask = 20'h0_ffff;
      `EMB_ADDR20: width_mask = 20'hf_ffff;
      default:     width_mask = 20'h0_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Word write holding latch
  // ---------------------------------------------------------------
  logic [7:0] hold_latch_reg;
  logic       tbl_lsb;
  logic       is_write;

  assign tbl_lsb  = req_in.addr[0];
  assign is_write = (req_in.kind == ACC_WRITE);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      hold_latch_reg <= 8'h00;
    else if (clk_en_in && access_go && phase == 3'h0 && is_write && data_width16_in
             && wmode == WMODE_WORD_WRITE && !tbl_lsb)
      hold_latch_reg <= req_in.table_latch;
  end

  // ---------------------------------------------------------------
  // Next pin state
  // ---------------------------------------------------------------
  bus_pins_s pins_next;
  logic [15:0] wdata;
  logic        drive_data;

  always_comb
  begin
    wdata      = {req_in.table_latch, req_in.table_latch};
    drive_data = 1'b1;
    if (data_width16_in && wmode == WMODE_WORD_WRITE)
    begin
      wdata = {req_in.table_latch, hold_latch_reg};
      drive_data = tbl_lsb;
    end
  end

  always_comb
  begin
    pins_next               = '0;
    pins_next.addr_data     = pins_out.addr_data;
    pins_next.oe_n          = 1'b1;
    pins_next.ce_n          = 1'b1;
    pins_next.write_high_n  = 1'b1;
    pins_next.write_low_n   = 1'b1;
    pins_next.upper_byte_n  = 1'b1;
    pins_next.lower_byte_n  = 1'b1;
    if (access_go && phase == 3'h0)
    begin
      pins_next.addr_data    = req_in.addr[20:1];
      pins_next.addr_data_oe = width_mask;
      pins_next.ale          = 1'b1;
      pins_next.ce_n         = 1'b0;
      pins_next.byte_addr_lsb = data_width16_in ? tbl_lsb : 1'b0;
    end
    else if (busy && phase != 3'h0)
    begin
      pins_next.ce_n         = 1'b0;
      pins_next.upper_byte_n = 1'b0;
      pins_next.lower_byte_n = 1'b0;
      pins_next.byte_addr_lsb = pins_out.byte_addr_lsb;
      if (is_write && phase == 3'h2)
      begin
        pins_next.addr_data[15:0] = wdata;
        pins_next.addr_data_oe = data_width16_in ? {4'h0, {16{drive_data}}} : 20'h0_00ff;
        pins_next.byte_addr_lsb = tbl_lsb;
        if (!data_width16_in)
          pins_next.write_high_n = 1'b0;
        else
        begin
          case (wmode)
            WMODE_BYTE_WRITE:
            begin
              pins_next.write_high_n = !tbl_lsb;
              pins_next.write_low_n  = tbl_lsb;
            end
            WMODE_WORD_WRITE:
              // high strobe on odd half only, even only loads the latch
              pins_next.write_high_n = !tbl_lsb;
            WMODE_BYTE_SELECT:
            begin
              pins_next.write_high_n = 1'b0;
              pins_next.upper_byte_n = !tbl_lsb;
              pins_next.lower_byte_n = tbl_lsb;
            end
            default:
              pins_next.write_high_n = 1'b1;
          endcase
        end
      end
      else if (!is_write && phase != 3'h3)
      begin
        pins_next.oe_n = 1'b0;
        if (!data_width16_in)
          pins_next.byte_addr_lsb = (phase == 3'h2);
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pins_out <= '0;
      pins_out.oe_n         <= 1'b1;
      pins_out.ce_n         <= 1'b1;
      pins_out.write_high_n <= 1'b1;
      pins_out.write_low_n  <= 1'b1;
      pins_out.upper_byte_n <= 1'b1;
      pins_out.lower_byte_n <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (powered_down)
      begin
        pins_out.ce_n         <= 1'b1;
        pins_out.upper_byte_n <= 1'b1;
        pins_out.lower_byte_n <= 1'b1;
      end
      else
        pins_out <= pins_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      read_word_out <= 16'h0000;
    else if (clk_en_in && !pins_out.oe_n && !powered_down)
    begin
      if (data_width16_in)
        read_word_out <= addr_data_in[15:0];
      else if (pins_out.byte_addr_lsb)
        read_word_out[15:8] <= addr_data_in[7:0];
      else
        read_word_out[7:0] <= addr_data_in[7:0];
    end
  end

  assign pin_is_bus_out = own_bus ? width_mask : 20'h0_0000;

endmodule : ext_bus_ctrl

// [common/ext_bus_regs.svh]
// Named offsets, field positions, reset values and timing figures for the bus block.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ---------------------------------------------------------------
// Control byte layout
// ---------------------------------------------------------------
`define CTRL_RELEASE_BIT   7
`define CTRL_WAIT_HI       5
`define CTRL_WAIT_LO       4
`define CTRL_WM_HI         1
`define CTRL_WM_LO         0
`define CTRL_WRITE_MASK    8'hb3
`define CTRL_RESET         8'h00

// ---------------------------------------------------------------
// Mode encodings
// ---------------------------------------------------------------
`define EMB_INTERNAL       2'h0
`define EMB_ADDR12         2'h1
`define EMB_ADDR16         2'h2
`define EMB_ADDR20         2'h3
`define WAIT_MAX           2'h3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define PHASE_NS           50
`define PHASE_CYCLES       ((`PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [common/ext_bus_pkg.sv]
// Types shared by the external memory bus controller and its phase sequencer.
// Assumes the constants header is on the include path.
`include "ext_bus_regs.svh"

package ext_bus_pkg;

  typedef enum logic [1:0] {
    WMODE_BYTE_WRITE,
    WMODE_BYTE_SELECT,
    WMODE_WORD_WRITE
  } write_mode_e;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_READ,
    ACC_WRITE
  } access_kind_e;

  // Core-side access request
  typedef struct packed {
    access_kind_e kind;
    logic [20:0]  addr;
    logic [7:0]   table_latch;
    logic         external;
  } access_req_s;

  // Pin-level bus state
  typedef struct packed {
    logic [19:0] addr_data;
    logic [19:0] addr_data_oe;
    logic        ale;
    logic        oe_n;
    logic        ce_n;
    logic        write_high_n;
    logic        write_low_n;
    logic        upper_byte_n;
    logic        lower_byte_n;
    logic        byte_addr_lsb;
  } bus_pins_s;

endpackage : ext_bus_pkg

// [verilog/ext_bus_phase.sv]
// Phase sequencer: steps one access through address, data and wait phases.
// Assumes a single clock and an enable shared with the controller.
`timescale 1ns/10ps

module ext_bus_phase
  import ext_bus_pkg::*;
#(
  parameter int PHASE_LEN = `PHASE_CYCLES
)
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic       start_in,
  input  wire logic [1:0] extra_in,
  output logic      [2:0] phase_out,
  output logic            busy_out,
  output logic            done_out
);

  // ---------------------------------------------------------------
  // Phase 0 address, 1 and 2 data halves, 3 for every wait cycle
  // ---------------------------------------------------------------
  logic [7:0] cnt_reg;
  logic [1:0] wait_reg;
  logic       last_slot;

  assign last_slot = (cnt_reg == 8'(PHASE_LEN - 1));
  assign busy_out  = (phase_out != 3'h0) || start_in;
  // Held request must not mask completion; waits end in phase 3
  assign done_out  = last_slot && (wait_reg == 2'h0)
                     && ((phase_out == 3'h2) || (phase_out == 3'h3));

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase_out <= 3'h0;
      cnt_reg   <= 8'h00;
      wait_reg  <= 2'h0;
    end
    else if (clk_en_in)
    begin
      if (start_in && phase_out == 3'h0)
      begin
        phase_out <= 3'h1;
        cnt_reg   <= 8'h00;
        wait_reg  <= extra_in;
      end
      else if (phase_out != 3'h0)
      begin
        if (!last_slot)
          cnt_reg <= cnt_reg + 8'h01;
        else
        begin
          cnt_reg <= 8'h00;
          if (phase_out == 3'h1)
            phase_out <= 3'h2;
          else if (wait_reg != 2'h0)
          begin
            wait_reg  <= wait_reg - 2'h1;
            phase_out <= 3'h3;
          end
          else
            phase_out <= 3'h0;
        end
      end
    end
  end

endmodule : ext_bus_phase

// [dv/ext_bus_mem_model.sv]
// Word-wide external memory seen from the bus pins.
// Assumes registered strobes from the controller.
`timescale 1ns/10ps
module ext_bus_mem_model
  import ext_bus_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        data_width16_in,
  input  wire bus_pins_s   pins_in,
  output logic      [19:0] addr_data_out
);
  logic [19:0] addr_reg;
  logic [19:0] last_reg = 20'h5_A5A5;
  logic [15:0] word;

  always_ff @(posedge clk_sys_in)
    if (pins_in.ale)
      addr_reg <= pins_in.addr_data;
  always_ff @(posedge clk_sys_in)
    if (!pins_in.oe_n)
      last_reg <= addr_data_out;
  assign word = {~addr_reg[7:0], addr_reg[7:0]};
  // Released lines show the inverse, so a stale sample never matches
  always_comb
    if (pins_in.oe_n)
      addr_data_out = ~last_reg;
    else if (data_width16_in)
      addr_data_out = {4'h0, word};
    else
      addr_data_out = {12'h000, pins_in.byte_addr_lsb ? word[15:8] : word[7:0]};
endmodule : ext_bus_mem_model

// [dv/ext_bus_ctrl_asserts.sv]
// Port checker for the bus controller.
// Assumes one clock domain and binding by port name.
`timescale 1ns/10ps
module ext_bus_ctrl_asserts
  import ext_bus_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        clk_en_in,
  input wire logic [1:0]  mem_bus_select_in,
  input wire logic        sleep_in,
  input wire logic        idle_in,
  input wire logic        exec_external_in,
  input wire logic        ctrl_write_in,
  input wire logic [7:0]  ctrl_wdata_in,
  input wire logic        req_valid_in,
  input wire logic [7:0]  bus_control_register_out,
  input wire logic        req_done_out,
  input wire bus_pins_s   pins_out,
  input wire logic [19:0] pin_is_bus_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_launch;
    $rose(pins_out.ale);
  endsequence
  sequence s_finish;
    req_done_out;
  endsequence

  a_int_no_bus:
    assert property (mem_bus_select_in == 2'h0 |-> pin_is_bus_out == 20'h0_0000)
    else $error("bus owns pins in internal mode");
  a_ctrl_locked:
    assert property (mem_bus_select_in == 2'h0 && ctrl_write_in && clk_en_in |=> $stable(bus_control_register_out))
    else $error("control byte written in internal mode");
  a_ctrl_mask:
    assert property (mem_bus_select_in != 2'h0 && ctrl_write_in && clk_en_in
      |=> bus_control_register_out == ($past(ctrl_wdata_in) & 8'hB3))
    else $error("control byte not stored");
  a_bus_held:
    assert property (mem_bus_select_in == 2'h3 && !bus_control_register_out[7] |-> pin_is_bus_out == 20'hF_FFFF)
    else $error("bus lost pins with release clear");
  a_release_io:
    assert property (mem_bus_select_in != 2'h0 && bus_control_register_out[7] && !exec_external_in
      && !$past(exec_external_in) && !req_valid_in && !$past(req_valid_in) |-> pin_is_bus_out == 20'h0_0000)
    else $error("pins not handed to ports");
  a_width_upper:
    assert property (mem_bus_select_in == 2'h2 |-> pin_is_bus_out[19:16] == 4'h0)
    else $error("upper lines taken at sixteen-bit width");
  a_sleep_sel:
    assert property ((sleep_in || idle_in) [*2] |-> pins_out.ce_n && pins_out.upper_byte_n && pins_out.lower_byte_n)
    else $error("selects low in sleep or idle");
  a_ale_done:
    assert property (s_launch |-> ##[1:4] s_finish)
    else $error("no completion after address latch");
  a_done_ce:
    assert property (s_finish |-> !pins_out.ce_n)
    else $error("chip select high during access");
  a_done_idle:
    assert property (s_finish |=> !pins_out.ale)
    else $error("address latch high after access");
endmodule : ext_bus_ctrl_asserts

bind ext_bus_ctrl ext_bus_ctrl_asserts chk_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
  .mem_bus_select_in(mem_bus_select_in), .sleep_in(sleep_in), .idle_in(idle_in),
  .exec_external_in(exec_external_in), .ctrl_write_in(ctrl_write_in), .ctrl_wdata_in(ctrl_wdata_in),
  .req_valid_in(req_valid_in), .bus_control_register_out(bus_control_register_out),
  .req_done_out(req_done_out), .pins_out(pins_out), .pin_is_bus_out(pin_is_bus_out));

// [dv/ext_bus_ctrl_test.sv]
// Self-checking bench for the external memory bus controller.
// Assumes package, memory model and checker compiled first.
`timescale 1ns/10ps
module ext_bus_ctrl_test
  import ext_bus_pkg::*;
;
  logic        clk_sys, rst_n, clk_en, dw16, wait_en, sleep, idle, exec_ext, cw, rv, done;
  logic        wh, wl, got_done, lsb_w;
  logic [1:0]  mbs, sel_n, oe_lsb;
  logic [7:0]  cwd, creg;
  logic [15:0] rword, wdata, oe_done;
  logic [19:0] mem_out, ad_in, p_oe, pib;
  access_req_s req;
  bus_pins_s   pins;
  int          n_fail, n_compared, n_cyc;

  assign ad_in = (pins.addr_data & pins.addr_data_oe) | (mem_out & ~pins.addr_data_oe);

  ext_bus_ctrl dut_u (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .clk_en_in(clk_en), .mem_bus_select_in(mbs),
    .data_width16_in(dw16), .wait_enable_in(wait_en), .sleep_in(sleep), .idle_in(idle),
    .exec_external_in(exec_ext), .ctrl_write_in(cw), .ctrl_wdata_in(cwd), .req_valid_in(rv), .req_in(req),
    .addr_data_in(ad_in), .periph_out_in(20'h0_0000), .periph_oe_in(p_oe), .bus_control_register_out(creg),
    .req_done_out(done), .read_word_out(rword), .pins_out(pins), .pin_is_bus_out(pib));
  ext_bus_mem_model mem_u (.clk_sys_in(clk_sys), .data_width16_in(dw16), .pins_in(pins), .addr_data_out(mem_out));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic set_ctrl(input logic [7:0] v);
    cw = 1'b1;
    cwd = v;
    tick();
    cw = 1'b0;
  endtask : set_ctrl

  task automatic snap();
    if (!pins.write_high_n || !pins.write_low_n)
    begin
      wdata = pins.addr_data[15:0];
      lsb_w = pins.byte_addr_lsb;
      sel_n = {pins.upper_byte_n, pins.lower_byte_n};
    end
    wh |= !pins.write_high_n;
    wl |= !pins.write_low_n;
    if (!pins.oe_n)
      oe_lsb[pins.byte_addr_lsb] = 1'b1;
    oe_done = pins.addr_data_oe[15:0];
  endtask : snap

  // Request held until done or twelve cycles; a missing completion ends the run only when one is wanted
  task automatic access(input access_kind_e k, input logic [20:0] a, input logic [7:0] l, input logic want);
    rv = 1'b1;
    req = '{k, a, l, 1'b1};
    {wh, wl, got_done, oe_lsb} = 5'h00;
    n_cyc = 0;
    while (n_cyc < 12 && !got_done)
    begin
      tick();
      n_cyc++;
      snap();
      got_done = (done === 1'b1);
    end
    rv = 1'b0;
    tick();
    snap();
    chk("done", 20'(want), 20'(got_done));
    if (want && !got_done)
      report_and_stop();
  endtask : access

  task automatic t_internal();
    mbs = 2'h0;
    set_ctrl(8'h80);
    chk("ctrl_locked", 20'h0_0000, 20'(creg));
    chk("port_pins", 20'h0_0000, pib);
    access(ACC_FETCH, 21'h00_0200, 8'h00, 1'b0);
  endtask : t_internal

  task automatic t_owner();
    mbs = 2'h3;
    p_oe = 20'hF_FFFF;
    exec_ext = 1'b1;
    set_ctrl(8'hFF);
    chk("ctrl_mask", 20'h0_00B3, 20'(creg));
    chk("held_external", 20'hF_FFFF, pib);
    exec_ext = 1'b0;
    tick();
    chk("released", 20'h0_0000, pib);
    set_ctrl(8'h00);
    tick();
    chk("bus_kept", 20'hF_FFFF, pib);
    chk("idle_levels", 20'h0_00FC, 20'({pins.ce_n, pins.oe_n, pins.write_high_n, pins.write_low_n,
      pins.upper_byte_n, pins.lower_byte_n, pins.ale, pins.byte_addr_lsb}));
    chk("idle_tri", 20'h0_0000, pins.addr_data_oe);
    mbs = 2'h2;
    tick();
    chk("width16", 20'h0_FFFF, pib);
    mbs = 2'h3;
    p_oe = 20'h0_0000;
  endtask : t_owner

  task automatic t_fetch(input logic w);
    dw16 = w;
    set_ctrl(8'hB0);
    // Distinct addresses per width, so a stale upper byte cannot pass
    access(ACC_FETCH, w ? 21'h00_0A4C : 21'h00_0A6E, 8'h00, 1'b1);
    tick();
    chk("fetch_word", w ? 20'h0_D926 : 20'h0_C837, 20'(rword));
    if (!w)
      chk("byte_halves", 20'h0_0003, 20'(oe_lsb));
  endtask : t_fetch

  // Word mode pairs go even then odd within one word
  task automatic t_writes();
    logic [7:0] l;
    logic [7:0] prev;
    logic [1:0] ex;
    dw16 = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      set_ctrl(8'h30 | 8'(m));
      for (int b = 0; b < 2; b++)
      begin
        l = 8'h20 + 8'(4 * m + b);
        access(ACC_WRITE, {20'h0_0040, b[0]}, l, 1'b1);
        ex = (m == 0) ? {b[0], !b[0]} : (m == 1 || b == 1) ? 2'b10 : 2'b00;
        chk("strobes", 20'(ex), 20'({wh, wl}));
        if (m >= 2 && b == 0)
          chk("even_tri", 20'h0_0000, 20'(oe_done));
        else
          chk("wdata", 20'({l, (m >= 2) ? prev : l}), 20'(wdata));
        if (m >= 1 && !(m >= 2 && b == 0))
          chk("byte_lsb", 20'(b[0]), 20'(lsb_w));
        if (m == 1)
          chk("byte_sel", 20'({!b[0], b[0]}), 20'(sel_n));
        if (m >= 2 && b == 1)
          chk("word_sel", 20'h0_0000, 20'(sel_n));
        prev = l;
      end
    end
  endtask : t_writes

  task automatic t_wait();
    wait_en = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      set_ctrl(8'h80 | 8'(c << 4));
      access(ACC_READ, 21'h00_0102, 8'h00, 1'b1);
      chk("wait_cycles", 20'(5 - c), 20'(n_cyc));
    end
    set_ctrl(8'h80);
    access(ACC_FETCH, 21'h00_0102, 8'h00, 1'b1);
    chk("fetch_cycles", 20'h0_0002, 20'(n_cyc));
    wait_en = 1'b0;
  endtask : t_wait

  task automatic t_sleep();
    for (int s = 0; s < 2; s++)
    begin
      {sleep, idle} = (s == 0) ? 2'b10 : 2'b01;
      tick();
      tick();
      chk("low_power_sel", 20'h0_0007, 20'({pins.ce_n, pins.upper_byte_n, pins.lower_byte_n}));
      access(ACC_FETCH, 21'h00_0300, 8'h00, 1'b0);
    end
    {sleep, idle} = 2'b00;
  endtask : t_sleep

  initial
  begin
    {rst_n, clk_en, dw16, wait_en, sleep, idle, exec_ext, cw, rv} = 9'h080;
    mbs = 2'h3;
    cwd = 8'h00;
    req = '0;
    p_oe = 20'h0_0000;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    tick();
    t_internal();
    t_owner();
    t_fetch(1'b1);
    t_fetch(1'b0);
    t_writes();
    t_wait();
    t_sleep();
    report_and_stop();
  end
endmodule : ext_bus_ctrl_test
